// *** include/lia_pkg.sv ***
// Constants for the line unit interrupt aggregator
package lia_pkg;

	// Geometry
	localparam int unsigned NCH       = 16;
	localparam int unsigned NSRC      = 20;
	localparam int unsigned REG_W     = 8;

	// Timing: one second counted on the 125 MHz clock
	localparam longint unsigned CLK_PERIOD_PS = 64'd8000;
	localparam longint unsigned SECOND_MS     = 64'd1000;
	localparam int unsigned SECOND_CYCLES =
		int'((SECOND_MS * 64'd1000000000) / CLK_PERIOD_PS);
	localparam int unsigned TMR_W = 32;

	// Flag register selector codes on the clear port
	localparam logic [1:0] SEL_FLAG_ZERO = 2'h0;
	localparam logic [1:0] SEL_FLAG_ONE  = 2'h1;
	localparam logic [1:0] SEL_FLAG_TWO  = 2'h2;

	// State register zero / flag register zero bit positions
	localparam int unsigned B0_LINE_LOS   = 0;
	localparam int unsigned B0_SYS_LOS    = 1;
	localparam int unsigned B0_TX_LOS     = 2;
	localparam int unsigned B0_TXCLK_LOSS = 3;
	localparam int unsigned B0_OUT_SHORT  = 4;
	localparam int unsigned B0_RX_JBUF    = 5;
	localparam int unsigned B0_TX_JBUF    = 6;
	localparam int unsigned B0_WAVE_OVF   = 7;

	// State register one / flag register one bit positions
	localparam int unsigned B1_LOOP_DOWN  = 0;
	localparam int unsigned B1_LOOP_UP    = 1;
	localparam int unsigned B1_PAT_SYNC   = 5;
	localparam int unsigned B1_LINE_AIS   = 6;
	localparam int unsigned B1_SYS_AIS    = 7;

	// Flag register two bit positions
	localparam int unsigned B2_CNT_WRAP   = 0;
	localparam int unsigned B2_PAT_BITERR = 1;
	localparam int unsigned B2_LINE_EXZ   = 2;
	localparam int unsigned B2_SYS_EXZ    = 3;
	localparam int unsigned B2_LINE_BPV   = 4;
	localparam int unsigned B2_SYS_BPV    = 5;

	// Edge select register bit positions
	localparam int unsigned ES_LOOP_CODE  = 0;
	localparam int unsigned ES_LOS        = 1;
	localparam int unsigned ES_TX_LOS     = 2;
	localparam int unsigned ES_TXCLK_LOSS = 3;
	localparam int unsigned ES_OUT_SHORT  = 4;
	localparam int unsigned ES_PAT_SYNC   = 5;
	localparam int unsigned ES_AIS        = 6;

	// Global config and timer flag register bit positions
	localparam int unsigned GC_SECOND_MASK = 0;
	localparam int unsigned GC_MASK_ALL    = 1;
	localparam int unsigned TF_SECOND      = 0;

	// Implemented bits of each register
	localparam logic [7:0] STATE0_USED = 8'h1F;
	localparam logic [7:0] EVT0_USED   = 8'hE0;
	localparam logic [7:0] STATE1_USED = 8'hE3;
	localparam logic [7:0] EVT2_USED   = 8'h3F;

	// Reset values
	localparam logic [7:0] FLAG_RST    = 8'h00;
	localparam logic [7:0] STATE_RST   = 8'h00;
	localparam logic       IRQ_N_RST   = 1'b1;

endpackage

// *** include/lia_tick_if.sv ***
// One-second tick carrier between the timer and the aggregator
`timescale 1ns/1ps
`default_nettype none

interface lia_tick_if;
	logic tick;

	modport src
	(
		output tick
	);

	modport snk
	(
		input  tick
	);
endinterface

`default_nettype wire

// *** rtl/lia_sec_timer.sv ***
// Free-running one-second period timer
`timescale 1ns/1ps
`default_nettype none

module lia_sec_timer #(
	parameter int unsigned SECOND_CYCLES = lia_pkg::SECOND_CYCLES
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           sys_rst_i,
	// Tick out
	lia_tick_if.src             tick_if
);

	localparam logic [lia_pkg::TMR_W-1:0] LAST =
		lia_pkg::TMR_W'(SECOND_CYCLES - 1);

	logic [lia_pkg::TMR_W-1:0] cnt_q;
	logic                      tick_q;

	// Count whole periods of the reference clock
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q == LAST)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign tick_if.tick = tick_q;

endmodule

`default_nettype wire

// *** rtl/lia_irq_aggregator.sv ***
// Per-channel and global interrupt flag aggregation with active-low request
`timescale 1ns/1ps
`default_nettype none

module lia_irq_aggregator #(
	parameter int unsigned SECOND_CYCLES = lia_pkg::SECOND_CYCLES
) (
	// Clock and reset
	input  wire logic                                    clk_i,
	input  wire logic                                    sys_rst_i,
	// Detector levels, laid out as state registers zero and one
	input  wire logic [lia_pkg::NCH-1:0][7:0]            state_zero_i,
	input  wire logic [lia_pkg::NCH-1:0][7:0]            state_one_i,
	// Detector one-cycle pulses, laid out as flag registers zero and two
	input  wire logic [lia_pkg::NCH-1:0][7:0]            evt_zero_i,
	input  wire logic [lia_pkg::NCH-1:0][7:0]            evt_two_i,
	// Configuration
	input  wire logic [lia_pkg::NCH-1:0][7:0]            edge_select_reg_i,
	input  wire logic [lia_pkg::NCH-1:0][7:0]            mask_reg_zero_i,
	input  wire logic [lia_pkg::NCH-1:0][7:0]            mask_reg_one_i,
	input  wire logic [lia_pkg::NCH-1:0][7:0]            mask_reg_two_i,
	input  wire logic [7:0]                              global_config_reg_i,
	// Write-one-to-clear port
	input  wire logic                                    clr_stb_i,
	input  wire logic [3:0]                              clr_chan_i,
	input  wire logic [1:0]                              clr_sel_i,
	input  wire logic [7:0]                              clr_bits_i,
	input  wire logic                                    timer_clr_i,
	// Status
	output logic      [lia_pkg::NCH-1:0][7:0]            state_reg_zero_o,
	output logic      [lia_pkg::NCH-1:0][7:0]            state_reg_one_o,
	output logic      [lia_pkg::NCH-1:0][7:0]            flag_reg_zero_o,
	output logic      [lia_pkg::NCH-1:0][7:0]            flag_reg_one_o,
	output logic      [lia_pkg::NCH-1:0][7:0]            flag_reg_two_o,
	output logic      [lia_pkg::NCH-1:0]                 channel_pending_summary_o,
	output logic      [7:0]                              timer_flag_reg_o,
	output logic                                         irq_n_o
);

	// Latch on rising edge, or on any change when any_edge is set
	function automatic logic [7:0] edge_hit(
		input logic [7:0] cur,
		input logic [7:0] prev,
		input logic [7:0] any_edge
	);
		edge_hit = (cur & ~prev) | (any_edge & (cur ^ prev));
	endfunction

	// Host clear strobe decode for one channel and one flag register
	function automatic logic [7:0] clr_hit(
		input logic       stb,
		input logic [3:0] chan,
		input logic [1:0] sel,
		input logic [7:0] bits,
		input int unsigned c,
		input logic [1:0] which
	);
		if (stb && (chan == 4'(c)) && (sel == which))
			clr_hit = bits;
		else
			clr_hit = 8'h00;
	endfunction

	// Spread edge select bits to state register zero positions
	function automatic logic [7:0] es_zero(input logic [7:0] es);
		logic [7:0] r;
		r = 8'h00;
		r[lia_pkg::B0_LINE_LOS]   = es[lia_pkg::ES_LOS];
		r[lia_pkg::B0_SYS_LOS]    = es[lia_pkg::ES_LOS];
		r[lia_pkg::B0_TX_LOS]     = es[lia_pkg::ES_TX_LOS];
		r[lia_pkg::B0_TXCLK_LOSS] = es[lia_pkg::ES_TXCLK_LOSS];
		r[lia_pkg::B0_OUT_SHORT]  = es[lia_pkg::ES_OUT_SHORT];
		es_zero = r;
	endfunction

	// Spread edge select bits to state register one positions
	function automatic logic [7:0] es_one(input logic [7:0] es);
		logic [7:0] r;
		r = 8'h00;
		r[lia_pkg::B1_LOOP_DOWN] = es[lia_pkg::ES_LOOP_CODE];
		r[lia_pkg::B1_LOOP_UP]   = es[lia_pkg::ES_LOOP_CODE];
		r[lia_pkg::B1_PAT_SYNC]  = es[lia_pkg::ES_PAT_SYNC];
		r[lia_pkg::B1_LINE_AIS]  = es[lia_pkg::ES_AIS];
		r[lia_pkg::B1_SYS_AIS]   = es[lia_pkg::ES_AIS];
		es_one = r;
	endfunction

	lia_tick_if tick_if ();

	logic [lia_pkg::NCH-1:0][7:0] state0_q;
	logic [lia_pkg::NCH-1:0][7:0] state1_q;
	logic [lia_pkg::NCH-1:0][7:0] flag0_q;
	logic [lia_pkg::NCH-1:0][7:0] flag1_q;
	logic [lia_pkg::NCH-1:0][7:0] flag2_q;
	logic [lia_pkg::NCH-1:0][7:0] flag0_d;
	logic [lia_pkg::NCH-1:0][7:0] flag1_d;
	logic [lia_pkg::NCH-1:0][7:0] flag2_d;
	logic [lia_pkg::NCH-1:0]      summary_q;
	logic [lia_pkg::NCH-1:0]      summary_d;
	logic                         second_flag_q;
	logic                         second_flag_d;
	logic                         irq_n_q;
	logic                         mask_all;

	assign mask_all = global_config_reg_i[lia_pkg::GC_MASK_ALL];

	lia_sec_timer #(
		.SECOND_CYCLES (SECOND_CYCLES)
	) u_sec_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_if   (tick_if.src)
	);

	// Per-channel flag next values
	genvar c;
	generate
		for (c = 0; c < lia_pkg::NCH; c++)
		begin : g_chan
			logic [7:0] set0;
			logic [7:0] set1;
			logic [7:0] set2;
			logic [7:0] clr0;
			logic [7:0] clr1;
			logic [7:0] clr2;

			// Level sources latch through edge selection
			assign set0 = (edge_hit(state_zero_i[c], state0_q[c],
				es_zero(edge_select_reg_i[c])) & lia_pkg::STATE0_USED)
				| (evt_zero_i[c] & lia_pkg::EVT0_USED);
			assign set1 = edge_hit(state_one_i[c], state1_q[c],
				es_one(edge_select_reg_i[c])) & lia_pkg::STATE1_USED;
			assign set2 = evt_two_i[c] & lia_pkg::EVT2_USED;

			assign clr0 = clr_hit(clr_stb_i, clr_chan_i, clr_sel_i, clr_bits_i, c,
				lia_pkg::SEL_FLAG_ZERO);
			assign clr1 = clr_hit(clr_stb_i, clr_chan_i, clr_sel_i, clr_bits_i, c,
				lia_pkg::SEL_FLAG_ONE);
			assign clr2 = clr_hit(clr_stb_i, clr_chan_i, clr_sel_i, clr_bits_i, c,
				lia_pkg::SEL_FLAG_TWO);

			// Write one clears; a same-cycle event wins
			assign flag0_d[c] = (flag0_q[c] & ~clr0) | set0;
			assign flag1_d[c] = (flag1_q[c] & ~clr1) | set1;
			assign flag2_d[c] = (flag2_q[c] & ~clr2) | set2;

			// Pending while any unmasked flag remains
			assign summary_d[c] = ~mask_all & (|(flag0_d[c] & ~mask_reg_zero_i[c])
				| |(flag1_d[c] & ~mask_reg_one_i[c])
				| |(flag2_d[c] & ~mask_reg_two_i[c]));
		end
	endgenerate

	// Global timer flag, set regardless of its mask
	assign second_flag_d = tick_if.tick
		| (second_flag_q & ~timer_clr_i);

	// Live state bits
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state0_q <= {lia_pkg::NCH{lia_pkg::STATE_RST}};
			state1_q <= {lia_pkg::NCH{lia_pkg::STATE_RST}};
		end
		else
		begin
			for (int i = 0; i < lia_pkg::NCH; i++)
			begin
				state0_q[i] <= state_zero_i[i] & lia_pkg::STATE0_USED;
				state1_q[i] <= state_one_i[i] & lia_pkg::STATE1_USED;
			end
		end
	end

	// Latched flags
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			flag0_q       <= {lia_pkg::NCH{lia_pkg::FLAG_RST}};
			flag1_q       <= {lia_pkg::NCH{lia_pkg::FLAG_RST}};
			flag2_q       <= {lia_pkg::NCH{lia_pkg::FLAG_RST}};
			second_flag_q <= 1'b0;
		end
		else
		begin
			flag0_q       <= flag0_d;
			flag1_q       <= flag1_d;
			flag2_q       <= flag2_d;
			second_flag_q <= second_flag_d;
		end
	end

	// Channel summary and request pin
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			summary_q <= '0;
			irq_n_q   <= lia_pkg::IRQ_N_RST;
		end
		else
		begin
			summary_q <= summary_d;
			irq_n_q   <= ~((|summary_d) | (second_flag_d & ~mask_all
				& ~global_config_reg_i[lia_pkg::GC_SECOND_MASK]));
		end
	end

	// Outputs, all straight from flip-flops
	assign state_reg_zero_o          = state0_q;
	assign state_reg_one_o           = state1_q;
	assign flag_reg_zero_o           = flag0_q;
	assign flag_reg_one_o            = flag1_q;
	assign flag_reg_two_o            = flag2_q;
	assign channel_pending_summary_o = summary_q;
	assign timer_flag_reg_o          = {7'h00, second_flag_q};
	assign irq_n_o                   = irq_n_q;

endmodule

`default_nettype wire

// *** verif/lia_irq_chk.sv ***
// Port assertions for the interrupt aggregator
`timescale 1ns/1ps
`default_nettype none

module lia_irq_chk (
	// Clock and reset
	input wire logic             clk_i,
	input wire logic             sys_rst_i,
	// Design inputs
	input wire logic [15:0][7:0] state_one_i,
	input wire logic [15:0][7:0] evt_two_i,
	input wire logic [15:0][7:0] edge_select_reg_i,
	input wire logic [15:0][7:0] mask_reg_one_i,
	input wire logic [15:0][7:0] mask_reg_two_i,
	input wire logic [7:0]       global_config_reg_i,
	input wire logic             clr_stb_i,
	input wire logic [3:0]       clr_chan_i,
	input wire logic [1:0]       clr_sel_i,
	// Design outputs
	input wire logic [15:0][7:0] flag_reg_one_o,
	input wire logic [15:0][7:0] flag_reg_two_o,
	input wire logic [15:0]      channel_pending_summary_o,
	input wire logic             irq_n_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	for (genvar g = 0; g < 16; g++)
	begin : ch_g
		clr_w1c_a: assert property (
			|($past(flag_reg_one_o[g]) & ~flag_reg_one_o[g])
			|-> $past(clr_stb_i && clr_chan_i == 4'(g) && clr_sel_i == 2'h1))
			else $error("flag dropped without clear");
		pulse_set_a: assert property (evt_two_i[g][1:0] != 2'h0 |=>
			(flag_reg_two_o[g][1:0] & $past(evt_two_i[g][1:0])) == $past(evt_two_i[g][1:0]))
			else $error("pulse not latched");
		rise_set_a: assert property ($rose(state_one_i[g][5]) |=> flag_reg_one_o[g][5])
			else $error("rise not latched");
		any_fall_a: assert property ($fell(state_one_i[g][5]) && !$past(sys_rst_i)
			&& edge_select_reg_i[g][5] |=> flag_reg_one_o[g][5])
			else $error("fall not latched in any-change mode");
		rise_only_a: assert property ($fell(state_one_i[g][5]) &&
			!edge_select_reg_i[g][5] && !flag_reg_one_o[g][5] |=> !flag_reg_one_o[g][5])
			else $error("fall latched in rising mode");
		loop_share_a: assert property ($fell(state_one_i[g][1]) && !$past(sys_rst_i)
			&& edge_select_reg_i[g][0] |=> flag_reg_one_o[g][1])
			else $error("shared edge select ignored");
		sum_set_a: assert property ((flag_reg_one_o[g] & ~$past(mask_reg_one_i[g])) != 8'h0
			&& !$past(global_config_reg_i[1]) |-> channel_pending_summary_o[g])
			else $error("summary low with pending flag");
		irq_pend_a: assert property ((flag_reg_two_o[g] & ~$past(mask_reg_two_i[g])) != 8'h0
			&& !$past(global_config_reg_i[1]) |-> !irq_n_o)
			else $error("request idle with pending flag");
	end

	cover property ($fell(irq_n_o));
	cover property ($rose(irq_n_o));
	cover property ($fell(|channel_pending_summary_o));
endmodule

`default_nettype wire

// *** verif/lia_host_model.sv ***
// Host model servicing the request pin with write-one clears
`timescale 1ns/1ps
`default_nettype none

module lia_host_model (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	// Service control
	input  wire logic             en_i,
	input  wire logic [3:0]       lag_i,
	// Device status
	input  wire logic             irq_n_i,
	input  wire logic [15:0]      pend_i,
	input  wire logic [15:0][7:0] f0_i,
	input  wire logic [15:0][7:0] f1_i,
	input  wire logic [15:0][7:0] f2_i,
	input  wire logic [7:0]       tflag_i,
	// Clear requests
	output logic                  clr_stb_o,
	output logic [3:0]            clr_chan_o,
	output logic [1:0]            clr_sel_o,
	output logic [7:0]            clr_bits_o,
	output logic                  timer_clr_o
);
	logic [3:0] wait_q;
	int         c;

	always @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			{clr_stb_o, clr_chan_o, clr_sel_o, clr_bits_o, timer_clr_o} <= '0;
			wait_q <= 4'h0;
		end
		else
		begin
			// Idle select and bits keep moving, channel holds, so stale values are not trusted
			clr_stb_o   <= 1'b0;
			timer_clr_o <= 1'b0;
			clr_bits_o  <= ~clr_bits_o;
			clr_sel_o   <= clr_sel_o + 2'h1;
			if (wait_q != 4'h0)
				wait_q <= wait_q - 4'h1;
			else if (en_i && !irq_n_i)
			begin
				c = 0;
				for (int i = 15; i >= 0; i--)
					if (pend_i[i])
						c = i;
				wait_q      <= lag_i;
				timer_clr_o <= tflag_i[0];
				clr_stb_o   <= pend_i[c];
				clr_chan_o  <= 4'(c);
				clr_sel_o   <= f0_i[c] != 8'h0 ? 2'h0 : f1_i[c] != 8'h0 ? 2'h1 : 2'h2;
				clr_bits_o  <= f0_i[c] != 8'h0 ? f0_i[c] : f1_i[c] != 8'h0 ? f1_i[c] : f2_i[c];
			end
		end
	end
endmodule

`default_nettype wire

// *** verif/lia_irq_aggregator_tb_top.sv ***
// Self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
`default_nettype none

module lia_irq_aggregator_tb_top;
	typedef struct packed {logic [3:0] ch; logic [1:0] sel; logic k; logic [9:0] v;} lia_note_t;
	logic             clk_i = 1'b0;
	logic             sys_rst_i = 1'b1;
	logic [15:0][7:0] st0, st1, ev0, ev2, es, m0, m1, m2, f0, f1, f2, sr0, sr1;
	logic [15:0]      summ;
	logic [7:0]       gcfg, clr_bits, tflag;
	logic [3:0]       clr_chan, lag, ch;
	logic [1:0]       clr_sel;
	logic             clr_stb, timer_clr, irq_n, en;
	lia_note_t        note_q[$];
	int               seed = 32'hFE00;
	int               err_total, samples_checked, cyc;
	event             seen;
	logic [7:0]       srcs[19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0D,
		8'h0E, 8'h0F, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D};

	lia_irq_aggregator #(.SECOND_CYCLES(20)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.state_zero_i(st0), .state_one_i(st1), .evt_zero_i(ev0), .evt_two_i(ev2),
		.edge_select_reg_i(es), .mask_reg_zero_i(m0), .mask_reg_one_i(m1),
		.mask_reg_two_i(m2), .global_config_reg_i(gcfg), .clr_stb_i(clr_stb),
		.clr_chan_i(clr_chan), .clr_sel_i(clr_sel), .clr_bits_i(clr_bits),
		.timer_clr_i(timer_clr), .state_reg_zero_o(sr0), .state_reg_one_o(sr1),
		.flag_reg_zero_o(f0), .flag_reg_one_o(f1), .flag_reg_two_o(f2),
		.channel_pending_summary_o(summ), .timer_flag_reg_o(tflag), .irq_n_o(irq_n));
	lia_host_model host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(en), .lag_i(lag),
		.irq_n_i(irq_n), .pend_i(summ), .f0_i(f0), .f1_i(f1), .f2_i(f2), .tflag_i(tflag),
		.clr_stb_o(clr_stb), .clr_chan_o(clr_chan), .clr_sel_o(clr_sel),
		.clr_bits_o(clr_bits), .timer_clr_o(timer_clr));

	always #4 clk_i = ~clk_i;

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED irq_sum_flag exp %h seen %h", exp, got);
		end
	endtask

	task automatic summarize();
		$display("checked %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic look(input logic [3:0] c, input logic [1:0] s, input logic [9:0] v);
		note_q.push_back('{c, s, 1'b0, v});
		-> seen;
	endtask

	// Same note, but compares the live state register instead of the flag
	task automatic look_st(input logic [3:0] c, input logic [1:0] s, input logic [9:0] v);
		note_q.push_back('{c, s, 1'b1, v});
		-> seen;
	endtask

	function automatic logic [1:0] sel_of(input logic [7:0] s);
		return s[4:3] == 2'h3 ? 2'h2 : s[4:3] == 2'h2 ? 2'h0 : s[4:3];
	endfunction

	// Level sources take the given value, pulse sources strobe one cycle
	task automatic fire(input logic [7:0] s, input logic val);
		case (s[4:3])
			2'h0: st0[ch][s[2:0]] = val;
			2'h1: st1[ch][s[2:0]] = val;
			2'h2: ev0[ch][s[2:0]] = 1'b1;
			default: ev2[ch][s[2:0]] = 1'b1;
		endcase
		@(negedge clk_i);
		ev0 = '0;
		ev2 = '0;
		repeat (2) @(negedge clk_i);
	endtask

	task automatic svc(input logic mid);
		en = 1'b1;
		lag = mid ? 4'hC : 4'($random(seed));
		if (mid)
		begin
			for (int i = 0; i < 60 && clr_stb !== 1'b1; i++)
				@(negedge clk_i);
			repeat (2) @(negedge clk_i);
			look(ch, 2'h2, 10'h102);
		end
		for (int i = 0; i < 200 && irq_n !== 1'b1; i++)
			@(negedge clk_i);
		repeat (2) @(negedge clk_i);
		en = 1'b0;
		@(negedge clk_i);
	endtask

	always @(seen)
	begin
		while (note_q.size() > 0)
		begin
			lia_note_t  n;
			logic [7:0] f;
			n = note_q.pop_front();
			f = n.sel == 2'h0 ? f0[n.ch] : n.sel == 2'h1 ? f1[n.ch] : n.sel == 2'h2 ? f2[n.ch] : tflag;
			if (n.k)
				f = n.sel == 2'h0 ? sr0[n.ch] : sr1[n.ch];
			chk({irq_n, summ[n.ch], f}, n.v);
		end
	end

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_total++;
			summarize();
		end
	end

	initial
	begin
		{st0, st1, ev0, ev2, es, m0, m1, m2} = '0;
		{gcfg, en, lag, ch} = {8'h01, 1'b0, 4'h0, 4'h0};
		repeat (10) @(negedge clk_i);
		sys_rst_i = 1'b0;
		@(negedge clk_i);
		look(4'h0, 2'h0, 10'h200);
		for (int m = 0; m < 2; m++)
		begin
			es = m ? '1 : '0;
			foreach (srcs[i])
			begin
				ch = 4'($random(seed));
				fire(srcs[i], 1'b1);
				look(ch, sel_of(srcs[i]), {2'h1, 8'h01 << srcs[i][2:0]});
				if (srcs[i][4] == 1'b0)
					look_st(ch, sel_of(srcs[i]), {2'h1, 8'h01 << srcs[i][2:0]});
				svc(1'b0);
				look(ch, sel_of(srcs[i]), 10'h200);
				if (srcs[i][4] == 1'b0)
				begin
					fire(srcs[i], 1'b0);
					look(ch, sel_of(srcs[i]), m ? {2'h1, 8'h01 << srcs[i][2:0]} : 10'h200);
					look_st(ch, sel_of(srcs[i]), m ? 10'h100 : 10'h200);
					if (m)
						svc(1'b0);
				end
			end
		end
		ch = 4'($random(seed));
		m1[ch] = 8'h20;
		fire(8'h0D, 1'b1);
		look(ch, 2'h1, 10'h220);
		fire(8'h19, 1'b1);
		look(ch, 2'h2, 10'h102);
		gcfg = 8'h03;
		repeat (2) @(negedge clk_i);
		look(ch, 2'h2, 10'h202);
		{gcfg, m1[ch]} = {8'h01, 8'h00};
		repeat (2) @(negedge clk_i);
		look(ch, 2'h1, 10'h120);
		svc(1'b1);
		look(ch, 2'h1, 10'h200);
		for (int i = 0; i < 40 && tflag[0] !== 1'b1; i++)
			@(negedge clk_i);
		look(4'h0, 2'h3, 10'h201);
		gcfg = 8'h00;
		repeat (2) @(negedge clk_i);
		look(4'h0, 2'h3, 10'h001);
		svc(1'b0);
		gcfg = 8'h01;
		summarize();
	end
endmodule

bind lia_irq_aggregator lia_irq_chk chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.state_one_i(state_one_i), .evt_two_i(evt_two_i), .edge_select_reg_i(edge_select_reg_i),
	.mask_reg_one_i(mask_reg_one_i), .mask_reg_two_i(mask_reg_two_i),
	.global_config_reg_i(global_config_reg_i), .clr_stb_i(clr_stb_i), .clr_chan_i(clr_chan_i),
	.clr_sel_i(clr_sel_i), .flag_reg_one_o(flag_reg_one_o), .flag_reg_two_o(flag_reg_two_o),
	.channel_pending_summary_o(channel_pending_summary_o), .irq_n_o(irq_n_o));

`default_nettype wire
